/* File: logic/mac_arith.sv */
// combinational product and sum with flag terms
`timescale 1ns/10ps
module mac_arith
(
  // operands
  input  wire logic [15:0] multiplierVal,
  input  wire logic [15:0] multiplicandVal,
  input  wire logic [31:0] addendVal,
  input  wire logic [2:0]  modeSel,
  // outcome
  output logic      [31:0] sumVal,
  output logic             ovfTerm,
  output logic             carryTerm
);
  logic        signedOp;
  logic        accum;
  logic [31:0] prod;
  logic [32:0] wide;

  always_comb
  begin
    signedOp = modeSel[1];
    accum    = modeSel[0];
    // operands widened first so no tool can keep a 16-bit product
    if (signedOp)
      prod = $signed({{16{multiplierVal[15]}}, multiplierVal})
           * $signed({{16{multiplicandVal[15]}}, multiplicandVal});
    else
      prod = {16'h0000, multiplierVal} * {16'h0000, multiplicandVal};
    wide = {1'b0, prod} + {1'b0, (accum ? addendVal : 32'h0000_0000)};
    sumVal = wide[31:0];
    carryTerm = accum & wide[32];
    // overflow only when like signs give an unlike sum
    ovfTerm = accum & signedOp & (prod[31] == addendVal[31])
            & (wide[31] != prod[31]);
  end
endmodule

/* File: logic/mac_pkg.sv */
// shared constants for the multiply-accumulate unit
package mac_pkg;
  localparam int unsigned OPW       = 16;
  localparam int unsigned RESW      = 32;
  localparam logic [2:0] MODE_UMUL  = 3'h0;
  localparam logic [2:0] MODE_UMAC  = 3'h1;
  localparam logic [2:0] MODE_SMUL  = 3'h2;
  localparam logic [2:0] MODE_SMAC  = 3'h3;
  localparam logic [2:0] MODE_RST   = 3'h0;
  // calculation length in machine cycles, never above three
  localparam int unsigned BUSY_FLAG_A_CYC  = 2;
  localparam logic [1:0] BUSY_FLAG_A_LAST  = 2'h1;
  localparam logic [31:0] RES_RST   = 32'h0000_0000;
  localparam logic [15:0] OPD_RST   = 16'h0000;
  // status vector bit positions
  localparam int unsigned ST_BUSY   = 0;
  localparam int unsigned ST_OVF    = 1;
  localparam int unsigned ST_CARRY  = 2;
  localparam int unsigned ST_SIGN   = 3;
  localparam int unsigned ST_ZERO   = 4;
  localparam int unsigned ST_W      = 5;
  localparam logic [4:0] ST_RST     = 5'h00;
endpackage

/* File: logic/mac_unit.sv */
// top of the 16x16 multiply and multiply-accumulate unit
// Operation
// - mode 000: unsigned 16x16 multiply, unsigned 32-bit product.
// - multiplier, low then high multiplicand; high write starts, replaces result.
// - mode 010: bit 15 of each operand is sign, signed multiply.
// - signed multiply: result bit 31 set when operand signs differ.
// - mode 001: unsigned product plus addend stored as result.
// - after each accumulate the result is copied into the addend.
// - an addend write also changes the result.
// - result-clear zeroes result and addend.
// - mode 011: signed product plus signed addend, signed sum.
// - signed accumulate: bit 31 is sum sign, inverted on overflow.
// - flags update only at completion or result-clear; reading status never alters them. Disabling the unit also clears them.
// - busy reads one only while calculating.
// - overflow on like-sign sum sign change in signed accumulate, else 0.
// - carry out of bit 31 in accumulate, else zero.
// - sign flag equals result bit 31; addend writes leave it.
// - zero flag when a completed result is all zero; result-clear drops it, addend writes leave it.
// - full unsigned or two's-complement operand and result ranges.
// - unit works only while enabled, stays enabled until cleared.
// - result-clear taken only when idle, self-clears after one cycle.
// - next operands may each be written once during a calculation.
`timescale 1ns/10ps
module mac_unit
(
  // clock and reset
  input  wire logic        clk_sys,
  input  wire logic        rst,
  // command bits
  input  wire logic        unitEnableBit,
  input  wire logic [2:0]  arithModeSel,
  input  wire logic        resultClearBit,
  // operand writes, one-cycle strobes with data
  input  wire logic        multiplierLowWr,
  input  wire logic        multiplierHighWr,
  input  wire logic        multiplicandLowWr,
  input  wire logic        multiplicandHighWr,
  input  wire logic [7:0]  wrData,
  // addend write, whole word
  input  wire logic        addendWr,
  input  wire logic [31:0] addendData,
  // results and status
  output logic      [31:0] resultVal,
  output logic      [15:0] multiplierVal,
  output logic      [15:0] multiplicandVal,
  output logic             resultClearEcho,
  output logic             busyFlagA,
  output logic             overflowFlag,
  output logic             carryOutFlag,
  output logic             signFlag,
  output logic             zeroResultFlag
);
  typedef enum logic [0:0] {MAC_IDLE, MAC_BUSY_FLAG_A} mac_state_e;

  mac_state_e  state_r;
  logic [1:0]  cnt_r;
  logic [15:0] mplr_r;
  logic [15:0] mcnd_r;
  logic [7:0]  mcndLow_r;
  logic        lowSeen_r;
  logic [15:0] opA_r;
  logic [15:0] opB_r;
  logic [2:0]  mode_r;
  logic [31:0] addend_r;
  logic [31:0] result_r;
  logic [4:0]  status_r;
  logic        clrEcho_r;
  logic        pend_r;
  logic [31:0] sumVal;
  logic        ovfTerm;
  logic        carryTerm;
  logic        startNow;
  logic        doneNow;
  logic        clrTake;

  ////////////////////////////////////////////////////////////////////////////
  // arithmetic datapath

  mac_arith u_arith
  (
    .multiplierVal   (opA_r),
    .multiplicandVal (opB_r),
    .addendVal       (addend_r),
    .modeSel         (mode_r),
    .sumVal          (sumVal),
    .ovfTerm         (ovfTerm),
    .carryTerm       (carryTerm)
  );

  ////////////////////////////////////////////////////////////////////////////
  // control decode

  // a high byte counts only after its low byte was written
  assign startNow = unitEnableBit & multiplicandHighWr & lowSeen_r;
  assign doneNow  = (state_r == MAC_BUSY_FLAG_A) && (cnt_r == mac_pkg::BUSY_FLAG_A_LAST);
  // clear refused while calculating
  assign clrTake  = unitEnableBit & resultClearBit & ~clrEcho_r
                  & (state_r == MAC_IDLE) & ~pend_r;

  ////////////////////////////////////////////////////////////////////////////
  // operand registers

  // operand writes accepted only while enabled; disable initialises
  always_ff @(posedge clk_sys)
  begin
    if (rst || !unitEnableBit)
    begin
      mplr_r    <= mac_pkg::OPD_RST;
      mcnd_r    <= mac_pkg::OPD_RST;
      mcndLow_r <= 8'h00;
      lowSeen_r <= 1'b0;
    end
    else
    begin
      if (multiplierLowWr)
        mplr_r[7:0] <= wrData;
      if (multiplierHighWr)
        mplr_r[15:8] <= wrData;
      if (multiplicandLowWr)
      begin
        mcndLow_r   <= wrData;
        mcnd_r[7:0] <= wrData;
        lowSeen_r   <= 1'b1;
      end
      else if (multiplicandHighWr)
        lowSeen_r <= 1'b0;
      // a lone high byte is not stored
      if (startNow)
        mcnd_r <= {wrData, mcndLow_r};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // sequencer

  // operands are latched at start, so the next set may be loaded once
  // while this one runs; a start during a run is held pending
  always_ff @(posedge clk_sys)
  begin
    if (rst || !unitEnableBit)
    begin
      state_r <= MAC_IDLE;
      cnt_r   <= 2'h0;
      opA_r   <= mac_pkg::OPD_RST;
      opB_r   <= mac_pkg::OPD_RST;
      mode_r  <= mac_pkg::MODE_RST;
      pend_r  <= 1'b0;
    end
    else
    begin
      case (state_r)
        MAC_IDLE:
        begin
          if (startNow || pend_r)
          begin
            state_r <= MAC_BUSY_FLAG_A;
            cnt_r   <= 2'h0;
            opA_r   <= mplr_r;
            opB_r   <= startNow ? {wrData, mcndLow_r} : mcnd_r;
            mode_r  <= arithModeSel;
            pend_r  <= 1'b0;
          end
        end
        MAC_BUSY_FLAG_A:
        begin
          // fixed length well inside the three-cycle budget
          if (doneNow)
            state_r <= MAC_IDLE;
          else
            cnt_r <= cnt_r + 2'h1;
          if (startNow)
            pend_r <= 1'b1;
        end
        default:
          state_r <= MAC_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // result and addend

  // the sum covers all four modes and full ranges
  // sign bits follow from two's complement
  always_ff @(posedge clk_sys)
  begin
    if (rst || !unitEnableBit || clrTake)
    begin
      result_r <= mac_pkg::RES_RST;
      addend_r <= mac_pkg::RES_RST;
    end
    else if (doneNow)
    begin
      result_r <= sumVal;
      if (mode_r[0])
        addend_r <= sumVal;
    end
    else if (addendWr && state_r == MAC_IDLE)
    begin
      // the result register mirrors the new addend
      addend_r <= addendData;
      result_r <= addendData;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // status flags

  // flags move only at completion, clear or disable; addend writes leave them
  always_ff @(posedge clk_sys)
  begin
    if (rst || !unitEnableBit || clrTake)
      status_r[mac_pkg::ST_ZERO:mac_pkg::ST_OVF] <= 4'h0;
    else if (doneNow)
    begin
      status_r[mac_pkg::ST_OVF]   <= ovfTerm;
      status_r[mac_pkg::ST_CARRY] <= carryTerm;
      status_r[mac_pkg::ST_SIGN]  <= sumVal[31];
      status_r[mac_pkg::ST_ZERO]  <= (sumVal == 32'h0000_0000);
    end
  end

  // busy high from the cycle after start until completion
  always_ff @(posedge clk_sys)
  begin
    if (rst || !unitEnableBit)
      status_r[mac_pkg::ST_BUSY] <= 1'b0;
    else if (startNow || pend_r)
      status_r[mac_pkg::ST_BUSY] <= 1'b1;
    else if (doneNow)
      status_r[mac_pkg::ST_BUSY] <= 1'b0;
  end

  // the clear bit echoes for one cycle, then drops by itself
  always_ff @(posedge clk_sys)
  begin
    if (rst)
      clrEcho_r <= 1'b0;
    else
      clrEcho_r <= clrTake;
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs

  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      resultVal       <= mac_pkg::RES_RST;
      multiplierVal   <= mac_pkg::OPD_RST;
      multiplicandVal <= mac_pkg::OPD_RST;
      resultClearEcho <= 1'b0;
    end
    else
    begin
      resultVal       <= result_r;
      multiplierVal   <= mplr_r;
      multiplicandVal <= mcnd_r;
      resultClearEcho <= clrEcho_r;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      busyFlagA      <= 1'b0;
      overflowFlag   <= 1'b0;
      carryOutFlag   <= 1'b0;
      signFlag       <= 1'b0;
      zeroResultFlag <= 1'b0;
    end
    else
    begin
      // busy shown at once with the start so software never sees a gap
      busyFlagA      <= status_r[mac_pkg::ST_BUSY] | startNow | pend_r;
      overflowFlag   <= status_r[mac_pkg::ST_OVF];
      carryOutFlag   <= status_r[mac_pkg::ST_CARRY];
      signFlag       <= status_r[mac_pkg::ST_SIGN];
      zeroResultFlag <= status_r[mac_pkg::ST_ZERO];
    end
  end
endmodule

/* File: sim/mac_cpu_model.sv */
// cpu-side model writing operands and addend into the unit
`timescale 1ns/10ps
module mac_cpu_model
(
  // clock and status
  input  wire logic        clk_sys,
  input  wire logic        busyFlagA,
  // strobes: multiplier low, high, multiplicand low, high
  output logic      [3:0]  wrStb,
  output logic      [7:0]  wrData,
  // addend
  output logic             addendWr,
  output logic      [31:0] addendData
);
  initial
  begin
    wrStb = 4'h0;
    wrData = 8'h5a;
    addendWr = 1'b0;
    addendData = 32'h0;
  end
  // called just after a falling edge; released lines show no stale data
  task automatic load(input logic [15:0] mpl, input logic [15:0] mpc);
    logic [31:0] b;
    b = {mpc, mpl};
    for (int i = 0; i < 4; i++)
    begin
      wrStb = 4'h1 << i;
      wrData = b[8*i +: 8];
      @(negedge clk_sys);
    end
    wrStb = 4'h0;
    wrData = ~wrData;
  endtask
  task automatic addend(input logic [31:0] v);
    for (int i = 0; i < 8 && busyFlagA; i++)
      @(negedge clk_sys);
    addendWr = 1'b1;
    addendData = v;
    @(negedge clk_sys);
    addendWr = 1'b0;
    addendData = ~v;
  endtask
  task automatic waitIdle(output bit ok);
    repeat (2) @(negedge clk_sys);
    for (int i = 0; i < 8 && busyFlagA !== 1'b0; i++)
      @(negedge clk_sys);
    ok = (busyFlagA === 1'b0);
  endtask
endmodule

/* File: sim/mac_unit_properties.sv */
// concurrent checks on the multiply-accumulate unit ports
`timescale 1ns/10ps
module mac_unit_properties
(
  // clock and reset
  input  wire logic        clk_sys,
  input  wire logic        rst,
  // control
  input  wire logic        unitEnableBit,
  input  wire logic [2:0]  arithModeSel,
  input  wire logic        resultClearBit,
  input  wire logic        multiplicandLowWr,
  input  wire logic        multiplicandHighWr,
  // outcome
  input  wire logic [31:0] resultVal,
  input  wire logic        resultClearEcho,
  input  wire logic        busyFlagA,
  input  wire logic        overflowFlag,
  input  wire logic        carryOutFlag,
  input  wire logic        signFlag,
  input  wire logic        zeroResultFlag
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  property p_start;
    (multiplicandLowWr && unitEnableBit) ##1
    (multiplicandHighWr && unitEnableBit) |-> ##2 busyFlagA;
  endproperty
  a_start: assert property (p_start)
    else $error("busy not raised after start");
  // six cycles leaves room for one queued start behind the first
  property p_finish;
    $rose(busyFlagA) |-> ##[1:6] !busyFlagA;
  endproperty
  a_finish: assert property (p_finish)
    else $error("calculation too long");
  property p_mulFlags;
    $fell(busyFlagA) && !arithModeSel[0] |-> !overflowFlag && !carryOutFlag;
  endproperty
  a_mulFlags: assert property (p_mulFlags)
    else $error("flag set in multiply mode");
  property p_sign;
    $fell(busyFlagA) |-> signFlag == resultVal[31];
  endproperty
  a_sign: assert property (p_sign)
    else $error("sign flag differs from result");
  property p_zero;
    $fell(busyFlagA) |-> zeroResultFlag == (resultVal == 32'h0);
  endproperty
  a_zero: assert property (p_zero)
    else $error("zero flag differs from result");
  property p_hold;
    (!busyFlagA && !resultClearEcho && unitEnableBit) ##1
    (!busyFlagA && !resultClearEcho && unitEnableBit) |->
      $stable({overflowFlag, carryOutFlag, signFlag, zeroResultFlag});
  endproperty
  a_hold: assert property (p_hold)
    else $error("flags moved without completion");
  property p_clear;
    resultClearEcho |-> resultVal == 32'h0 ##1 !resultClearEcho;
  endproperty
  a_clear: assert property (p_clear)
    else $error("clear echo or result wrong");
  property p_clrBusy;
    resultClearBit && busyFlagA |-> ##2 !resultClearEcho;
  endproperty
  a_clrBusy: assert property (p_clrBusy)
    else $error("clear taken while busy");
  property p_off;
    !unitEnableBit [*2] |=> resultVal == 32'h0 && !busyFlagA;
  endproperty
  a_off: assert property (p_off)
    else $error("disabled unit kept state");
endmodule
bind mac_unit mac_unit_properties u_mac_unit_properties
(
  .clk_sys(clk_sys), .rst(rst), .unitEnableBit(unitEnableBit),
  .arithModeSel(arithModeSel), .resultClearBit(resultClearBit),
  .multiplicandLowWr(multiplicandLowWr),
  .multiplicandHighWr(multiplicandHighWr), .resultVal(resultVal),
  .resultClearEcho(resultClearEcho), .busyFlagA(busyFlagA),
  .overflowFlag(overflowFlag), .carryOutFlag(carryOutFlag),
  .signFlag(signFlag), .zeroResultFlag(zeroResultFlag)
);

/* File: sim/mac_unit_test.sv */
// self-checking bench for the multiply-accumulate unit
`timescale 1ns/10ps
`define CHK(nm, e, a) \
  begin cmpCount++; if ((a) !== (e)) begin errorCnt++; \
  $display("mismatch %s exp %h got %h", nm, e, a); end end
module mac_unit_test;
  logic        clk_sys = 1'b0;
  logic        rst = 1'b1;
  logic        unitEnableBit = 1'b0;
  logic [2:0]  arithModeSel = 3'h0;
  logic        resultClearBit = 1'b0;
  logic [3:0]  wrStb;
  logic [7:0]  wrData;
  logic        addendWr;
  logic [31:0] addendData;
  logic [31:0] resultVal;
  logic [15:0] mplrOut;
  logic [15:0] mcndOut;
  logic [31:0] acc = 32'h0;
  logic        resultClearEcho;
  logic        busyFlagA;
  logic        overflowFlag;
  logic        carryOutFlag;
  logic        signFlag;
  logic        zeroResultFlag;
  logic        sExp = 1'b0;
  logic        zExp = 1'b0;
  int          errorCnt = 0;
  int          cmpCount = 0;
  always #2.5 clk_sys = ~clk_sys;
  mac_unit u_mac_unit
  (
    .clk_sys(clk_sys), .rst(rst), .unitEnableBit(unitEnableBit),
    .arithModeSel(arithModeSel), .resultClearBit(resultClearBit),
    .multiplierLowWr(wrStb[0]), .multiplierHighWr(wrStb[1]),
    .multiplicandLowWr(wrStb[2]), .multiplicandHighWr(wrStb[3]),
    .wrData(wrData), .addendWr(addendWr), .addendData(addendData),
    .resultVal(resultVal), .multiplierVal(mplrOut),
    .multiplicandVal(mcndOut),
    .resultClearEcho(resultClearEcho), .busyFlagA(busyFlagA),
    .overflowFlag(overflowFlag), .carryOutFlag(carryOutFlag),
    .signFlag(signFlag), .zeroResultFlag(zeroResultFlag)
  );
  mac_cpu_model u_mac_cpu_model
  (
    .clk_sys(clk_sys), .busyFlagA(busyFlagA), .wrStb(wrStb),
    .wrData(wrData), .addendWr(addendWr), .addendData(addendData)
  );
  ////////////////////////////////////////////////////////////////
  task automatic results();
    $display("compares %0d mismatches %0d", cmpCount, errorCnt);
    if (errorCnt == 0 && cmpCount > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic idle();
    bit ok;
    u_mac_cpu_model.waitIdle(ok);
    if (!ok)
    begin
      errorCnt++;
      results();
    end
  endtask
  task automatic run(input logic [2:0] m, input logic [15:0] a, b,
                     input logic wa, input logic [31:0] ad);
    logic signed [31:0] p;
    logic [32:0]        s;
    logic               ov;
    if (wa)
    begin
      u_mac_cpu_model.addend(ad);
      acc = ad;
      repeat (3) @(negedge clk_sys);
      `CHK("addend result", ad, resultVal)
      `CHK("zero kept", zExp, zeroResultFlag)
      `CHK("sign kept", sExp, signFlag)
    end
    arithModeSel = m;
    if (m[1])
      p = $signed(a) * $signed(b);
    else
      p = a * b;
    s = m[0] ? {1'b0, p} + {1'b0, acc} : {1'b0, p};
    ov = (m == mac_pkg::MODE_SMAC) && p[31] == acc[31] && s[31] != p[31];
    u_mac_cpu_model.load(a, b);
    idle();
    `CHK("result", s[31:0], resultVal)
    `CHK("multiplier", a, mplrOut)
    `CHK("multiplicand", b, mcndOut)
    `CHK("overflow", ov, overflowFlag)
    `CHK("carry", m[0] & s[32], carryOutFlag)
    sExp = s[31];
    zExp = (s[31:0] == 32'h0);
    `CHK("sign", sExp, signFlag)
    `CHK("zero", zExp, zeroResultFlag)
    if (m[0])
      acc = s[31:0];
  endtask
  ////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (10) @(negedge clk_sys);
    rst = 1'b0;
    unitEnableBit = 1'b1;
    @(negedge clk_sys);
    run(mac_pkg::MODE_UMUL, 16'hffff, 16'hffff, 1'b0, 32'h0);
    run(mac_pkg::MODE_SMUL, 16'h8000, 16'h7fff, 1'b0, 32'h0);
    run(mac_pkg::MODE_SMUL, 16'h8000, 16'h8000, 1'b0, 32'h0);
    $display("test multiply done");
    run(mac_pkg::MODE_UMAC, 16'h0001, 16'hffff, 1'b1, 32'hffff0001);
    run(mac_pkg::MODE_UMAC, 16'h0002, 16'h0003, 1'b0, 32'h0);
    run(mac_pkg::MODE_UMAC, 16'h0002, 16'h0003, 1'b0, 32'h0);
    run(mac_pkg::MODE_SMAC, 16'h7fff, 16'h7fff, 1'b1, 32'h7fffffff);
    run(mac_pkg::MODE_SMAC, 16'hffff, 16'h0001, 1'b0, 32'h0);
    $display("test accumulate done");
    resultClearBit = 1'b1;
    @(negedge clk_sys);
    resultClearBit = 1'b0;
    @(negedge clk_sys);
    `CHK("clear echo", 1'b1, resultClearEcho)
    `CHK("clear result", 32'h0, resultVal)
    acc = 32'h0;
    sExp = 1'b0;
    zExp = 1'b0;
    @(negedge clk_sys);
    `CHK("echo drop", 1'b0, resultClearEcho)
    run(mac_pkg::MODE_UMAC, 16'h0003, 16'h0003, 1'b0, 32'h0);
    // a clear held across the run must be refused
    u_mac_cpu_model.load(16'h0004, 16'h0005);
    resultClearBit = 1'b1;
    repeat (2) @(negedge clk_sys);
    resultClearBit = 1'b0;
    idle();
    `CHK("clear refused", 32'h0000001d, resultVal)
    `CHK("no echo", 1'b0, resultClearEcho)
    $display("test clear done");
    unitEnableBit = 1'b0;
    repeat (3) @(negedge clk_sys);
    `CHK("off result", 32'h0, resultVal)
    `CHK("off zero", 1'b0, zeroResultFlag)
    unitEnableBit = 1'b1;
    acc = 32'h0;
    sExp = 1'b0;
    zExp = 1'b0;
    @(negedge clk_sys);
    run(mac_pkg::MODE_UMUL, 16'h0000, 16'h1234, 1'b0, 32'h0);
    $display("test enable done");
    results();
  end
endmodule
